// ### design/lhp_consts.vh
`ifndef LHP_CONSTS_VH
`define LHP_CONSTS_VH
// ==========================================================
// display ram geometry
`define LHP_COLS           132
`define LHP_COL_LAST       8'h83
`define LHP_PAGE_LAST      4'h8
`define LHP_LINES          65
`define LHP_LINE_LAST      7'h40
// ==========================================================
// status byte fields
`define LHP_ST_BUSY        7
`define LHP_ST_ADC         6
// ==========================================================
// command opcodes (upper bits) and masks
`define LHP_CMD_START_MSK  8'hC0
`define LHP_CMD_START      8'h40
`define LHP_CMD_PAGE_MSK   8'hF0
`define LHP_CMD_PAGE       8'hB0
`define LHP_CMD_COLH       8'h10
`define LHP_CMD_COLL       8'h00
`define LHP_CMD_ADC_MSK    8'hFE
`define LHP_CMD_ADC        8'hA0
`define LHP_CMD_COM_MSK    8'hF0
`define LHP_CMD_COM        8'hC0
// ==========================================================
// reset values
`define LHP_RST_BYTE       8'h00
// ==========================================================
// timing: internal processing after a command, in ns, rounded up to cycles
`define LHP_BUSY_NS        10
`define LHP_CLK_NS         5
`define LHP_BUSY_CYC       ((`LHP_BUSY_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)
`endif

// ### design/lhp_ram.v
`include "lhp_consts.vh"
// ==========================================================
// display ram: host port plus independent refresh read port
module lhp_ram #(
  parameter DEPTH = 9 * `LHP_COLS,
  parameter AW    = 11
) (
  // clock
  input  wire          mclk_i,
  input  wire          ce_i,
  // host port
  input  wire          we_i,
  input  wire [AW-1:0] addr_i,
  input  wire [7:0]    wdata_i,
  output reg  [7:0]    rdata_o,
  // refresh port
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]    rfdata_o
);
  reg [7:0] mem [0:DEPTH-1];
  always @(posedge mclk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o  <= mem[addr_i];
      rfdata_o <= mem[raddr_i];
    end
  end
endmodule // lhp_ram

// ### design/lhp_serial.v
`include "lhp_consts.vh"
// ==========================================================
// write-only serial shifter
module lhp_serial (
  // clock and reset
  input  wire       mclk_i,
  input  wire       resetn_i,
  input  wire       ce_i,
  // serial pins, sampled synchronously
  input  wire       active_i,
  input  wire       sclk_i,
  input  wire       sdata_i,
  input  wire       dc_i,
  // byte out
  output reg        valid_o,
  output reg  [7:0] byte_o,
  output reg        is_data_o
);
  reg [6:0] shift;
  reg [2:0] count;
  reg       sclk_d;
  wire      rise = sclk_i & ~sclk_d;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      shift     <= 7'h00;
      count     <= 3'h0;
      sclk_d    <= 1'b0;
      valid_o   <= 1'b0;
      byte_o    <= `LHP_RST_BYTE;
      is_data_o <= 1'b0;
    end else if (ce_i) begin
      sclk_d  <= sclk_i;
      valid_o <= 1'b0;
      if (!active_i) begin
        shift <= 7'h00;
        count <= 3'h0;
      end else if (rise) begin
        shift <= {shift[5:0], sdata_i};
        count <= count + 3'h1;
        if (count == 3'h7) begin
          valid_o   <= 1'b1;
          byte_o    <= {shift, sdata_i};
          is_data_o <= dc_i;
        end
      end
    end
  end
endmodule // lhp_serial

// ### design/lhp_host_port.v
`include "lhp_consts.vh"
module lhp_host_port #(
  parameter BUSY_CYC = `LHP_BUSY_CYC
) (
  // clock, enable, reset
  input  wire        mclk_i,
  input  wire        ce_i,
  input  wire        resetn_i,
  // configuration pins
  input  wire        parallel_select_i,
  input  wire        bus_family_select_i,
  // host bus
  input  wire        chip_select_low_active_n_i,
  input  wire        chip_select_high_active_i,
  input  wire        data_command_select_i,
  input  wire        rd_strobe_i,
  input  wire        wr_strobe_i,
  input  wire [7:0]  data_i,
  output reg  [7:0]  data_o,
  output wire        data_oe_o,
  // refresh side
  input  wire [6:0]  refresh_line_i,
  input  wire [7:0]  refresh_segment_i,
  output wire        refresh_bit_o,
  // settings shown to the display logic
  output reg  [6:0]  start_line_o,
  output reg         seg_reverse_o,
  output reg         com_reverse_o,
  output wire        busy_o
);
  // ==========================================================
  // access decode
  wire active = ~chip_select_low_active_n_i & chip_select_high_active_i;
  wire par    = parallel_select_i;
  // strobe style: high picks enable + r/w, low picks separate low strobes
  wire acc_on   = bus_family_select_i ? rd_strobe_i : (~rd_strobe_i | ~wr_strobe_i);
  wire acc_read = bus_family_select_i ? wr_strobe_i : ~rd_strobe_i;
  reg  acc_d;
  reg  read_d;
  reg  dc_d;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc_d  <= 1'b0;
      read_d <= 1'b0;
      dc_d   <= 1'b0;
    end else if (ce_i) begin
      acc_d  <= active & par & acc_on;
      read_d <= acc_read;
      dc_d   <= data_command_select_i;
    end
  end
  // cycle ends on trailing strobe edge; data/address settled by then
  wire par_end  = acc_d & ~(active & par & acc_on);
  wire s_valid;
  wire [7:0] s_byte;
  wire s_is_data;
  lhp_serial u_ser (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .active_i  (active & ~par),
    .sclk_i    (data_i[6]),
    .sdata_i   (data_i[7]),
    .dc_i      (data_command_select_i),
    .valid_o   (s_valid),
    .byte_o    (s_byte),
    .is_data_o (s_is_data)
  );
  wire [7:0] wbyte  = par ? data_i : s_byte;
  wire       wr_dat = par ? (par_end & ~read_d &  dc_d) : (s_valid &  s_is_data);
  wire       wr_cmd = par ? (par_end & ~read_d & ~dc_d) : (s_valid & ~s_is_data);
  wire       rd_dat = par_end & read_d & dc_d;
  wire       rd_st  = par_end & read_d & ~dc_d;
  // ==========================================================
  // addressing
  reg [3:0] page;
  reg [7:0] column;
  reg [3:0] busy_cnt;
  assign busy_o = (busy_cnt != 4'h0);
  function [10:0] ram_addr;
    input [3:0] p;
    input [7:0] c;
    // sized operands keep the product inside the 11-bit address
    ram_addr = ({7'h00, p} * 11'h084) + {3'h0, c};
  endfunction
  function [7:0] col_step;
    input [7:0] c;
    col_step = (c == `LHP_COL_LAST) ? c : c + 8'h01;
  endfunction
  reg [7:0]  hold;
  reg        pend;
  reg [10:0] pend_addr;
  reg        fetch;
  wire [7:0] ram_q;
  wire [7:0] ref_q;
  // ==========================================================
  // commands, data path
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      page          <= 4'h0;
      column        <= 8'h00;
      start_line_o  <= 7'h00;
      seg_reverse_o <= 1'b0;
      com_reverse_o <= 1'b0;
      busy_cnt      <= 4'h0;
      hold          <= `LHP_RST_BYTE;
      pend          <= 1'b0;
      pend_addr     <= 11'h000;
      fetch         <= 1'b0;
    end else if (ce_i) begin
      fetch <= 1'b0;
      pend  <= 1'b0;
      if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
      if (wr_cmd && !busy_o) begin
        busy_cnt <= BUSY_CYC[3:0];
        fetch    <= 1'b1;
        if ((wbyte & `LHP_CMD_START_MSK) == `LHP_CMD_START) begin
          start_line_o <= {1'b0, wbyte[5:0]};
        end else if ((wbyte & `LHP_CMD_PAGE_MSK) == `LHP_CMD_PAGE) begin
          page <= (wbyte[3:0] > `LHP_PAGE_LAST) ? `LHP_PAGE_LAST : wbyte[3:0];
        end else if ((wbyte & `LHP_CMD_PAGE_MSK) == `LHP_CMD_COLH) begin
          column <= {wbyte[3:0], column[3:0]};
        end else if ((wbyte & `LHP_CMD_PAGE_MSK) == `LHP_CMD_COLL) begin
          column <= {column[7:4], wbyte[3:0]};
        end else if ((wbyte & `LHP_CMD_ADC_MSK) == `LHP_CMD_ADC) begin
          seg_reverse_o <= wbyte[0];
        end else if ((wbyte & `LHP_CMD_COM_MSK) == `LHP_CMD_COM) begin
          com_reverse_o <= wbyte[3];
        end
      end else if (wr_dat) begin
        // written byte waits in holder, committed next cycle
        hold      <= (page == `LHP_PAGE_LAST) ? {7'h00, wbyte[0]} : wbyte;
        pend      <= 1'b1;
        pend_addr <= ram_addr(page, column);
        column    <= col_step(column);
      end else if (rd_dat) begin
        column <= col_step(column);
        fetch  <= 1'b1;
      end
      if (fetch) begin
        // holder refills after the read, so next read sees it
        hold <= (page == `LHP_PAGE_LAST) ? {7'h00, ram_q[0]} : ram_q;
      end
    end
  end
  // ==========================================================
  // host read output
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      data_o <= `LHP_RST_BYTE;
    end else if (ce_i) begin
      if (active & par & acc_on & acc_read) begin
        if (data_command_select_i) begin
          data_o <= hold;
        end else begin
          data_o <= {busy_o, seg_reverse_o, 6'h00};
        end
      end
    end
  end
  assign data_oe_o = active & par & acc_on & acc_read;
  // ==========================================================
  // refresh addressing: line offset by start line, column by direction
  wire [7:0] line_sum = {1'b0, refresh_line_i} + {1'b0, start_line_o};
  wire [6:0] ram_line = (line_sum >= `LHP_LINES) ? line_sum[6:0] - 7'd65 : line_sum[6:0];
  wire [7:0] ram_col  = seg_reverse_o ? `LHP_COL_LAST - refresh_segment_i : refresh_segment_i;
  reg  [2:0] bit_sel;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      bit_sel <= 3'h0;
    end else if (ce_i) begin
      bit_sel <= ram_line[2:0];
    end
  end
  assign refresh_bit_o = ref_q[bit_sel];
  wire [10:0] host_addr = pend ? pend_addr : ram_addr(page, column);
  lhp_ram u_ram (
    .mclk_i   (mclk_i),
    .ce_i     (ce_i),
    .we_i     (pend),
    .addr_i   (host_addr),
    .wdata_i  (hold),
    .rdata_o  (ram_q),
    .raddr_i  (ram_addr(ram_line[6:3], ram_col)),
    .rfdata_o (ref_q)
  );
endmodule // lhp_host_port

// ### tb/lhp_host_properties.sv
// ==========================================================
// host port checker
module lhp_host_properties #(
  parameter BUSY_CYC = 2
) (
  input logic       mclk_i,
  input logic       resetn_i,
  input logic       parallel_select_i,
  input logic       bus_family_select_i,
  input logic       chip_select_low_active_n_i,
  input logic       chip_select_high_active_i,
  input logic       rd_strobe_i,
  input logic       wr_strobe_i,
  input logic [7:0] data_o,
  input logic       data_oe_o,
  input logic [6:0] start_line_o,
  input logic       seg_reverse_o,
  input logic       com_reverse_o,
  input logic       busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic       sel;
  logic [3:0] bcnt;
  assign sel = !chip_select_low_active_n_i && chip_select_high_active_i;
  // busy run counted so its length stays a parameter
  always @(posedge mclk_i) begin
    if (!resetn_i) bcnt <= 4'h0;
    else bcnt <= busy_o ? bcnt + 4'h1 : 4'h0;
  end
  a_oe_needs_select: assert property (data_oe_o |-> sel) else $error("driven while deselected");
  a_serial_no_read: assert property (!parallel_select_i |-> !data_oe_o) else $error("driven in serial");
  a_oe_strobe_style: assert property (sel && parallel_select_i |->
    data_oe_o == (bus_family_select_i ? rd_strobe_i && wr_strobe_i : !rd_strobe_i)) else $error("bad drive");
  a_busy_length: assert property ($fell(busy_o) |-> bcnt == BUSY_CYC) else $error("busy length");
  a_read_hold: assert property ($changed(data_o) |-> data_oe_o || $past(data_oe_o))
    else $error("read data moved");
  a_idle_settings: assert property (!sel && !$past(sel) |->
    $stable({start_line_o, seg_reverse_o, com_reverse_o})) else $error("setting moved while idle");
  a_start_in_range: assert property (start_line_o <= 7'h40) else $error("start line range");
  a_setting_by_cmd: assert property ($changed({start_line_o, seg_reverse_o, com_reverse_o})
    |-> ##[0:1] busy_o) else $error("setting moved without command");
endmodule // lhp_host_properties

bind lhp_host_port lhp_host_properties #(.BUSY_CYC(BUSY_CYC)) u_props (.*);

// ### tb/lhp_host_model.sv
// ==========================================================
// host master: both strobe styles and serial
module lhp_host_model (
  input  wire       mclk_i,
  input  wire       style_i,
  input  wire [7:0] rdata_i,
  output reg        csn_o = 1'b1,
  output reg        cs_o  = 1'b0,
  output reg        dc_o  = 1'b0,
  output reg        rd_o  = 1'b1,
  output reg        wr_o  = 1'b1,
  output reg  [7:0] d_o   = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  task acc(input logic en, input logic dc, input logic rd, input logic [7:0] w, output logic [7:0] r);
    begin
      @(posedge mclk_i);
      csn_o <= ~en;
      cs_o <= en;
      dc_o <= dc;
      d_o <= w;
      rd_o <= ~style_i;
      wr_o <= rd;
      @(posedge mclk_i);
      rd_o <= style_i | ~rd;
      repeat (3) @(posedge mclk_i);
      r = rdata_i;
      rd_o <= ~style_i;
      wr_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      csn_o <= 1'b1;
      cs_o <= 1'b0;
      // released bus shows no stale value
      d_o <= ~d_o;
    end
  endtask
  // strobes and low data pins stay put in serial mode
  task ser(input logic dc, input logic [7:0] b, input int n);
    int i;
    begin
      @(posedge mclk_i);
      csn_o <= 1'b0;
      cs_o <= 1'b1;
      dc_o <= ~dc;
      d_o[6] <= 1'b0;
      for (i = 0; i < n; i++) begin
        d_o[7] <= b[7-i];
        if (i == 7) dc_o <= dc;
        repeat (2) @(posedge mclk_i);
        d_o[6] <= 1'b1;
        repeat (2) @(posedge mclk_i);
        d_o[6] <= 1'b0;
      end
      repeat (6) @(posedge mclk_i);
      csn_o <= 1'b1;
      cs_o <= 1'b0;
    end
  endtask
endmodule // lhp_host_model

// ### tb/tb.sv
// ==========================================================
// top bench
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk_i = 1'b0, ce_i = 1'b1, resetn_i = 1'b0, parallel_select_i = 1'b1, bus_family_select_i = 1'b0;
  logic       chip_select_low_active_n_i, chip_select_high_active_i, data_command_select_i, rd_strobe_i;
  logic       wr_strobe_i, data_oe_o, refresh_bit_o, seg_reverse_o, com_reverse_o, busy_o;
  logic [7:0] data_i, data_o, d, refresh_segment_i = 8'h00, r, w, c, b1, b2;
  logic [6:0] refresh_line_i = 7'h00, start_line_o;
  logic [5:0] s;
  logic [3:0] p;
  logic [7:0] sh [0:131];
  int         seed = 96, err_total = 0, total_checks = 0, cyc = 0, i, k;
  assign data_i = data_oe_o ? data_o : d;
  lhp_host_port #(.BUSY_CYC(2)) u_dut (.*);
  lhp_host_model u_host (.mclk_i(mclk_i), .style_i(bus_family_select_i), .rdata_i(data_o),
    .csn_o(chip_select_low_active_n_i), .cs_o(chip_select_high_active_i), .dc_o(data_command_select_i),
    .rd_o(rd_strobe_i), .wr_o(wr_strobe_i), .d_o(d));
  initial forever #2.5 mclk_i = ~mclk_i;
  // ==========================================================
  // expectations and helpers
  function automatic logic [7:0] held(input logic [3:0] pg, input logic [7:0] v);
    held = (pg == 4'h8) ? (v & 8'h01) : v;
  endfunction
  function automatic logic [7:0] next_col(input logic [7:0] col);
    next_col = (col == 8'h83) ? col : col + 8'h01;
  endfunction
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    begin
      total_checks++;
      if (got !== exp) begin
        err_total++;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task xfer(input logic dcv, input logic rdv, input logic [7:0] v);
    u_host.acc(1'b1, dcv, rdv, v, r);
  endtask
  task setpc(input logic [3:0] pg, input logic [7:0] col);
    begin
      xfer(1'b0, 1'b0, {4'hB, pg});
      xfer(1'b0, 1'b0, {4'h1, col[7:4]});
      xfer(1'b0, 1'b0, {4'h0, col[3:0]});
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    chk("reset", 8'h00, {start_line_o, seg_reverse_o});
    chk("reset", 8'h00, {5'h00, com_reverse_o, busy_o, data_oe_o});
    for (k = 0; k < 2; k++) begin
      bus_family_select_i <= k[0];
      p = k ? 4'h8 : $random(seed) & 4'h7;
      c = 8'h7E;
      setpc(p, c);
      // eight writes run past the last column
      for (i = 0; i < 8; i++) begin
        w = $random(seed);
        sh[c] = held(p, w);
        xfer(1'b1, 1'b0, w);
        c = next_col(c);
      end
      setpc(p, 8'h7E);
      u_host.acc(1'b0, 1'b1, 1'b0, 8'hFF, r);
      xfer(1'b1, 1'b1, 8'h00);
      for (i = 'h7E; i < 'h85; i++) begin
        xfer(1'b1, 1'b1, 8'h00);
        chk("ram", sh[i > 'h83 ? 'h83 : i], r);
      end
      xfer(1'b0, 1'b0, {7'h50, k[0]});
      xfer(1'b0, 1'b1, 8'h00);
      chk("status", {1'b0, k[0], 6'h00}, r);
    end
    parallel_select_i <= 1'b0;
    b1 = $random(seed);
    b2 = $random(seed);
    u_host.ser(1'b1, 8'hFF, 3);
    u_host.ser(1'b0, 8'hB2, 8);
    u_host.ser(1'b0, 8'h10, 8);
    u_host.ser(1'b0, 8'h05, 8);
    u_host.ser(1'b1, b1, 8);
    u_host.ser(1'b1, b2, 8);
    parallel_select_i <= 1'b1;
    setpc(4'h2, 8'h05);
    xfer(1'b1, 1'b1, 8'h00);
    xfer(1'b1, 1'b1, 8'h00);
    chk("serial", b1, r);
    xfer(1'b1, 1'b1, 8'h00);
    chk("serial", b2, r);
    s = $random(seed);
    xfer(1'b0, 1'b0, {2'b01, s});
    xfer(1'b0, 1'b0, 8'hC8);
    repeat (2) @(posedge mclk_i);
    chk("start", {2'b00, s}, {1'b0, start_line_o});
    chk("com", 8'h01, {7'h00, com_reverse_o});
    xfer(1'b0, 1'b0, 8'hC0);
    // column 5 lands on segment 126 while reversed
    refresh_segment_i <= 8'h7E;
    for (k = 0; k < 8; k++) begin
      refresh_line_i <= (k + 'h51 - s) % 'h41;
      repeat (4) @(posedge mclk_i);
      chk("pixel", {7'h00, b1[k]}, {7'h00, refresh_bit_o});
    end
    tally_and_finish;
  end
endmodule // tb
